/* rtl/ots_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ots_regs.svh"
module ots_sequencer
  import ots_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Limit switches, high means at the limit
  input wire logic forward_limit_input,
  input wire logic reverse_limit_input,
  // Servo conditions
  input wire logic servo_on_in,
  input wire logic servo_alarm_in,
  input wire logic power_loss_in,
  input wire logic torque_mode_in,
  input wire logic motor_stopped_in,
  // Motor control path
  output logic inhibit_fwd_q,
  output logic inhibit_rev_q,
  output logic dyn_brake_q,
  output logic coast_q,
  output logic decel_q,
  output logic [15:0] stop_torque_value_q,
  output logic zero_clamp_q,
  output logic servo_off_q,
  // Interrupt
  output logic irq_q
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] wdat,
                                             input logic [3:0] sel);
    logic [15:0] r;
    r = old_v;
    if (sel[0]) begin
      r[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wdat[15:8];
    end
    return r;
  endfunction : lane_merge

  function automatic logic [15:0] torque_limit(input logic [15:0] v);
    return (v > `OTS_MAX_TORQUE) ? `OTS_MAX_TORQUE : v;
  endfunction : torque_limit

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [4:0] raw_in;
  logic [4:0] syn_in;
  logic fwd_lim;
  logic rev_lim;
  logic son;
  logic alarm;
  logic ploss;

  assign raw_in = {power_loss_in, servo_alarm_in, servo_on_in,
                   reverse_limit_input, forward_limit_input};

  ots_sync #(.W(5)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(raw_in),
    .sync_out(syn_in)
  );

  assign fwd_lim = syn_in[0];
  assign rev_lim = syn_in[1];
  assign son = syn_in[2];
  assign alarm = syn_in[3];
  assign ploss = syn_in[4];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] fsw_q;
  logic [15:0] fsw_d;
  logic [15:0] est_q;
  logic [15:0] est_d;
  logic [`OTS_IRQ_W-1:0] ist_q;
  logic [`OTS_IRQ_W-1:0] ist_d;
  logic [`OTS_IRQ_W-1:0] imask_q;
  logic [`OTS_IRQ_W-1:0] imask_d;
  logic [31:0] rdat_d;
  logic ack_d;
  logic wr_en;
  logic [`OTS_IRQ_W-1:0] ev_set;
  ots_state_t state_q;
  ots_state_t state_d;
  ots_state_t off_stop;

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

  always_comb begin
    fsw_d = fsw_q;
    est_d = est_q;
    imask_d = imask_q;
    ist_d = ist_q;
    ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;
    rdat_d = 32'h0000_0000;
    if (wr_en) begin
      unique case (wb_adr_i)
        `OTS_ADR_FSW: fsw_d = lane_merge(fsw_q, wb_dat_i, wb_sel_i);
        `OTS_ADR_EST: est_d = lane_merge(est_q, wb_dat_i, wb_sel_i);
        `OTS_ADR_IRQ: begin
          if (wb_sel_i[0]) begin
            ist_d = ist_q & ~wb_dat_i[`OTS_IRQ_W-1:0];
          end
        end
        `OTS_ADR_MASK: begin
          if (wb_sel_i[0]) begin
            imask_d = wb_dat_i[`OTS_IRQ_W-1:0];
          end
        end
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    ist_d = ist_d | ev_set;
    unique case (wb_adr_i)
      `OTS_ADR_FSW: rdat_d = {16'h0000, fsw_q};
      `OTS_ADR_EST: rdat_d = {16'h0000, est_q};
      `OTS_ADR_STAT: rdat_d = {16'h0000, 5'h00, syn_in, state_q,
                               inhibit_rev_q, inhibit_fwd_q, servo_off_q};
      `OTS_ADR_IRQ: rdat_d = {28'h0000000, ist_q};
      `OTS_ADR_MASK: rdat_d = {28'h0000000, imask_q};
      default: rdat_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fsw_q <= `OTS_FSW_RESET;
      est_q <= `OTS_EST_RESET;
      ist_q <= '0;
      imask_q <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      fsw_q <= fsw_d;
      est_q <= est_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      wb_ack_o <= ack_d;
      wb_dat_o <= rdat_d;
    end
  end

  // ----------------------------------------
  // Overtravel decision
  // ----------------------------------------
  logic fwd_ot;
  logic rev_ot;
  logic fwd_ot_q;
  logic rev_ot_q;
  logic ot_new;
  logic off_cause;
  logic ot_decel;

  // Limit high means at the limit; set ignore bit masks it
  assign fwd_ot = fwd_lim && !fsw_q[`OTS_FSW_FWD_IGN];
  assign rev_ot = rev_lim && !fsw_q[`OTS_FSW_REV_IGN];
  assign ot_new = (fwd_ot && !fwd_ot_q) || (rev_ot && !rev_ot_q);
  assign off_cause = !son || alarm || ploss;
  // Torque mode forces the servo-off style stop
  assign ot_decel = fsw_q[`OTS_FSW_OT_DECEL] && !torque_mode_in;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fwd_ot_q <= 1'b0;
      rev_ot_q <= 1'b0;
    end else begin
      fwd_ot_q <= fwd_ot;
      rev_ot_q <= rev_ot;
    end
  end

  // ----------------------------------------
  // Stop sequencer
  // ----------------------------------------
  // Servo-off stop entry point
  assign off_stop = fsw_q[`OTS_FSW_COAST] ? OTS_COAST : OTS_BRAKE;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      OTS_RUN: begin
        if (off_cause) begin
          state_d = off_stop;
        end else if (ot_new) begin
          state_d = ot_decel ? OTS_DECEL : off_stop;
        end
      end
      OTS_DECEL: begin
        if (off_cause) begin
          state_d = off_stop;
        end else if (motor_stopped_in) begin
          state_d = fsw_q[`OTS_FSW_OT_CLAMP] ? OTS_CLAMP : OTS_IDLE;
        end
      end
      OTS_CLAMP: begin
        if (off_cause) begin
          state_d = off_stop;
        end else if (!fwd_ot && !rev_ot) begin
          state_d = OTS_RUN;
        end
      end
      OTS_BRAKE: begin
        if (motor_stopped_in) begin
          state_d = fsw_q[`OTS_FSW_DB_KEEP] ? OTS_HELD : OTS_IDLE;
        end
      end
      OTS_COAST: begin
        if (motor_stopped_in) begin
          state_d = OTS_IDLE;
        end
      end
      OTS_HELD, OTS_IDLE: begin
        // Restart only once every stop cause has gone
        if (!off_cause && !fwd_ot && !rev_ot) begin
          state_d = OTS_RUN;
        end
      end
      default: state_d = OTS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= OTS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Events
  // ----------------------------------------
  always_comb begin
    ev_set = '0;
    ev_set[`OTS_IRQ_FWD] = fwd_ot && !fwd_ot_q;
    ev_set[`OTS_IRQ_REV] = rev_ot && !rev_ot_q;
    ev_set[`OTS_IRQ_OFF] = (state_d == OTS_BRAKE || state_d == OTS_COAST)
                           && state_q != state_d;
    ev_set[`OTS_IRQ_STOP] = (state_d == OTS_HELD || state_d == OTS_IDLE
                             || state_d == OTS_CLAMP)
                            && state_q != state_d;
  end

  // ----------------------------------------
  // Outputs, registered from next state; inhibits from the overtravel decision
  // ----------------------------------------
  logic inh_fwd_d;
  logic inh_rev_d;
  logic db_d;
  logic coast_d;
  logic decel_d;
  logic clamp_d;
  logic off_d;
  logic irq_d;
  logic [15:0] trq_d;

  always_comb begin
    inh_fwd_d = fwd_ot;
    inh_rev_d = rev_ot;
    db_d = (state_d == OTS_BRAKE) || (state_d == OTS_HELD);
    coast_d = state_d == OTS_COAST;
    decel_d = state_d == OTS_DECEL;
    clamp_d = state_d == OTS_CLAMP;
    off_d = (state_d != OTS_RUN) && (state_d != OTS_DECEL)
            && (state_d != OTS_CLAMP);
    // Torque only matters during the overtravel deceleration
    trq_d = decel_d ? torque_limit(est_q) : 16'h0000;
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inhibit_fwd_q <= 1'b0;
      inhibit_rev_q <= 1'b0;
      dyn_brake_q <= 1'b0;
      coast_q <= 1'b0;
      decel_q <= 1'b0;
      zero_clamp_q <= 1'b0;
      servo_off_q <= 1'b1;
      stop_torque_value_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      inhibit_fwd_q <= inh_fwd_d;
      inhibit_rev_q <= inh_rev_d;
      dyn_brake_q <= db_d;
      coast_q <= coast_d;
      decel_q <= decel_d;
      zero_clamp_q <= clamp_d;
      servo_off_q <= off_d;
      stop_torque_value_q <= trq_d;
      irq_q <= irq_d;
    end
  end

endmodule : ots_sequencer
`default_nettype wire

/* rtl/ots_regs.svh */
`ifndef OTS_REGS_SVH
`define OTS_REGS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define OTS_ADR_FSW 8'h00
`define OTS_ADR_EST 8'h04
`define OTS_ADR_STAT 8'h08
`define OTS_ADR_IRQ 8'h0c
`define OTS_ADR_MASK 8'h10

// ----------------------------------------
// Reset values and torque limit
// ----------------------------------------
`define OTS_FSW_RESET 16'h0080
`define OTS_EST_RESET 16'h0064
`define OTS_MAX_TORQUE 16'h012c

// ----------------------------------------
// Select word fields
// ----------------------------------------
`define OTS_FSW_FWD_IGN 2
`define OTS_FSW_REV_IGN 3
`define OTS_FSW_COAST 6
`define OTS_FSW_DB_KEEP 7
`define OTS_FSW_OT_DECEL 8
`define OTS_FSW_OT_CLAMP 9

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define OTS_IRQ_FWD 0
`define OTS_IRQ_REV 1
`define OTS_IRQ_OFF 2
`define OTS_IRQ_STOP 3
`define OTS_IRQ_W 4

`endif

/* rtl/ots_pkg.sv */
package ots_pkg;

  // Gray codes along run -> stop -> stopped, except BRAKE -> IDLE (3'h2 -> 3'h5)
  typedef enum logic [2:0] {
    OTS_RUN = 3'h0,
    OTS_DECEL = 3'h1,
    OTS_CLAMP = 3'h3,
    OTS_BRAKE = 3'h2,
    OTS_HELD = 3'h6,
    OTS_COAST = 3'h4,
    OTS_IDLE = 3'h5
  } ots_state_t;

endpackage : ots_pkg

/* rtl/ots_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ots_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // First stage feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : ots_sync
`default_nettype wire

/* tb/ots_sequencer_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ots_regs.svh"
module ots_sequencer_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Pins
  input wire logic forward_limit_input,
  input wire logic servo_alarm_in,
  input wire logic torque_mode_in,
  // Motor path
  input wire logic inhibit_fwd_q,
  input wire logic dyn_brake_q,
  input wire logic coast_q,
  input wire logic decel_q,
  input wire logic [15:0] stop_torque_value_q,
  input wire logic zero_clamp_q
);
  // ----
  // Checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Five samples cover sync, decision and output flop
  sequence s_fwd_clear;
    !forward_limit_input [*5];
  endsequence
  sequence s_alarm_held;
    servo_alarm_in [*5];
  endsequence
  a_ack_answer:
    assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack stuck");
  a_fwd_allowed:
    assert property (s_fwd_clear |-> !inhibit_fwd_q)
    else $error("forward inhibited while clear");
  a_torque_idle:
    assert property (!decel_q |-> stop_torque_value_q == 16'h0)
    else $error("torque outside decel");
  a_torque_cap:
    assert property (stop_torque_value_q <= `OTS_MAX_TORQUE)
    else $error("torque above max");
  a_clamp_after_decel:
    assert property ($rose(zero_clamp_q) |-> $past(decel_q))
    else $error("clamp without decel");
  a_brake_coast_excl:
    assert property (!(dyn_brake_q && coast_q)) else $error("brake and coast");
  a_alarm_stop:
    assert property (s_alarm_held |-> !decel_q && !zero_clamp_q)
    else $error("alarm did not force servo-off stop");
  a_torque_mode_stop:
    assert property (torque_mode_in [*4] |-> !$rose(decel_q))
    else $error("decel in torque mode");
endmodule : ots_sequencer_monitor

bind ots_sequencer ots_sequencer_monitor i_mon (.clk(clk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .forward_limit_input(forward_limit_input), .servo_alarm_in(servo_alarm_in),
  .torque_mode_in(torque_mode_in), .inhibit_fwd_q(inhibit_fwd_q),
  .dyn_brake_q(dyn_brake_q), .coast_q(coast_q), .decel_q(decel_q),
  .stop_torque_value_q(stop_torque_value_q), .zero_clamp_q(zero_clamp_q));
`default_nettype wire

/* tb/ots_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ots_motor_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Drive state, coast-down length
  input wire logic run,
  input wire logic [3:0] slow,
  // Standstill report
  output logic motor_stopped
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  // Motor spins down over slow cycles once drive stops
  always_comb begin
    cnt_d = cnt_q;
    if (run) begin
      cnt_d = 4'h0;
    end else if (cnt_q < slow) begin
      cnt_d = cnt_q + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 4'hf;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign motor_stopped = !run && (cnt_q >= slow);
endmodule : ots_motor_model
`default_nettype wire

/* tb/ots_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ots_sequencer_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, ack, fwd, rev, son, alarm, ploss, tq;
  logic stopped, inh_f, inh_r, brake, coast, decel, clamp, soff, irq, run;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, slow;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] torque;
  int err_count = 0;
  int tests_run = 0;
  always #25 clk = ~clk;
  assign run = !soff && !decel && !clamp && !brake && !coast;
  ots_sequencer i_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(ack), .forward_limit_input(fwd), .reverse_limit_input(rev),
    .servo_on_in(son), .servo_alarm_in(alarm), .power_loss_in(ploss),
    .torque_mode_in(tq), .motor_stopped_in(stopped), .inhibit_fwd_q(inh_f),
    .inhibit_rev_q(inh_r), .dyn_brake_q(brake), .coast_q(coast),
    .decel_q(decel), .stop_torque_value_q(torque), .zero_clamp_q(clamp),
    .servo_off_q(soff), .irq_q(irq));
  ots_motor_model i_motor (.clk(clk), .resetn(resetn), .run(run),
    .slow(slow), .motor_stopped(stopped));
  // ----
  // Helpers
  // ----
  task automatic complete_run();
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic we, logic [7:0] a, logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h3;
    @(posedge clk iff ack === 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, {16'h0, d}, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, logic [15:0] e, string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, {16'h0, e}, q);
  endtask : rd
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold
  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    rd(8'h00, 16'h0080, "fsw reset");
    rd(8'h04, 16'h0064, "est reset");
    wr(8'h14, 16'hffff);
    rd(8'h14, 16'h0000, "unmapped");
    wr(8'h04, 16'h0190);
    rd(8'h04, 16'h0190, "est rw");
    son <= 1'b1;
    hold(6);
    chk("run soff", 32'h0, 32'(soff));
    rd(8'h08, 16'h0100, "status run");
  endtask : t_regs
  task automatic t_decel(input logic [15:0] fsw, logic clamp_on);
    wr(8'h00, fsw);
    fwd <= clamp_on;
    rev <= !clamp_on;
    hold(6);
    chk("inh fwd", 32'(clamp_on), 32'(inh_f));
    chk("inh rev", 32'(!clamp_on), 32'(inh_r));
    chk("decel", 32'h1, 32'(decel));
    chk("torque cap", 32'h012c, 32'(torque));
    hold(12);
    chk("clamp", 32'(clamp_on), 32'(clamp));
    chk("off after", 32'(!clamp_on), 32'(soff));
    fwd <= 1'b0;
    rev <= 1'b0;
    hold(6);
    chk("back run", 32'h0, 32'(clamp | soff));
  endtask : t_decel
  task automatic t_brake();
    wr(8'h00, 16'h0000);
    fwd <= 1'b1;
    hold(6);
    chk("ot brake", 32'h1, 32'(brake));
    chk("ot no decel", 32'h0, 32'(decel));
    hold(12);
    chk("brake free", 32'h0, 32'(brake));
    fwd <= 1'b0;
    wr(8'h00, 16'h0140);
    tq <= 1'b1;
    rev <= 1'b1;
    hold(6);
    chk("tq decel", 32'h0, 32'(decel));
    chk("tq coast", 32'h1, 32'(coast));
    rev <= 1'b0;
    tq <= 1'b0;
    hold(14);
    chk("coast end", 32'h0, 32'(coast));
  endtask : t_brake
  task automatic t_ignore();
    wr(8'h00, 16'h000c);
    fwd <= 1'b1;
    rev <= 1'b1;
    hold(6);
    chk("ign fwd", 32'h0, 32'(inh_f));
    chk("ign rev", 32'h0, 32'(inh_r));
    chk("ign stop", 32'h0, 32'(brake | decel));
    fwd <= 1'b0;
    rev <= 1'b0;
  endtask : t_ignore
  task automatic t_alarm();
    slow <= 4'h1;
    wr(8'h00, 16'h0080);
    wr(8'h0c, 16'h000f);
    wr(8'h10, 16'h0004);
    rd(8'h10, 16'h0004, "mask rw");
    alarm <= 1'b1;
    hold(6);
    chk("alarm brake", 32'h1, 32'(brake));
    chk("irq set", 32'h1, 32'(irq));
    hold(4);
    chk("brake kept", 32'h1, 32'(brake));
    rd(8'h0c, 16'h000c, "irq status");
    wr(8'h0c, 16'h0004);
    hold(2);
    chk("irq clear", 32'h0, 32'(irq));
    rd(8'h0c, 16'h0008, "irq w1c");
    alarm <= 1'b0;
    hold(6);
    ploss <= 1'b1;
    hold(6);
    chk("loss brake", 32'h1, 32'(brake));
    ploss <= 1'b0;
    hold(6);
    son <= 1'b0;
    hold(6);
    chk("son off", 32'h1, 32'(soff));
  endtask : t_alarm
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, fwd, rev, son, alarm, ploss, tq} = '0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    slow = 4'h8;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_decel(16'h0380, 1'b1);
    t_decel(16'h0180, 1'b0);
    t_brake();
    t_ignore();
    t_alarm();
    complete_run();
  end
  // Run needs about 200 cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule : ots_sequencer_tb_top
`default_nettype wire
